// File: core/pim_consts.svh
`ifndef PIM_CONSTS_SVH
`define PIM_CONSTS_SVH

// input counts: four logic inputs, two dry contact inputs
`define PIM_NUM_LOGIC 4
`define PIM_NUM_DRY   2
`define PIM_NUM_IN    6

// command word and per-input function code widths
`define PIM_CMD_W 16
`define PIM_CFG_W 5

// front panel lock item mask width
`define PIM_ITEMS_W 8

// debounce setting is in microseconds
`define PIM_FILT_W    16
`define PIM_TICK_NS   1000
`define PIM_CLK_NS    8
`define PIM_TICK_CYC  ((`PIM_TICK_NS + `PIM_CLK_NS - 1) / `PIM_CLK_NS)
`define PIM_SUB_W     7
`define PIM_SUB_LAST  7'((`PIM_TICK_CYC) - 1)

// command bits that follow the input level rather than pulse on its rise
`define PIM_LEVEL_MASK 16'hc101

`endif

// File: core/pim_pkg.sv
`include "pim_consts.svh"

package pim_pkg;

  typedef enum logic [4:0] {
    FN_DISABLED    = 5'h00,
    FN_MOTION      = 5'h01,
    FN_STOP        = 5'h02,
    FN_PRODUCTION  = 5'h03,
    FN_FLUIDIC     = 5'h04,
    FN_REFERENCE   = 5'h05,
    FN_CLEAR_FAULT = 5'h06,
    FN_CLEAR_ALERT = 5'h07,
    FN_LOAD        = 5'h08,
    FN_CROSSOVER   = 5'h09,
    FN_PARK        = 5'h0a,
    FN_UNPARK      = 5'h0b,
    FN_UNSTICK     = 5'h0c,
    FN_TORQUE      = 5'h0d,
    FN_CLEAR_REQ   = 5'h0e,
    FN_GATE_PROD   = 5'h0f,
    FN_GATE_FLUID  = 5'h10,
    FN_PANEL_LOCK  = 5'h11
  } input_func_type;

  typedef struct packed {
    logic                   act;
    logic [`PIM_SUB_W-1:0]  sub;
    logic [`PIM_FILT_W-1:0] cnt;
    logic                   filt;
  } filter_state_type;

  typedef struct packed {
    logic [`PIM_NUM_IN-1:0]   prev;
    logic [`PIM_CMD_W-1:0]    cmd;
    logic                     lock;
    logic [`PIM_ITEMS_W-1:0]  items;
    logic [`PIM_NUM_IN-1:0]   vals;
    logic [`PIM_NUM_LOGIC-1:0] lout;
    logic [`PIM_NUM_DRY-1:0]  aout;
  } mapper_state_type;

endpackage

// File: core/input_filter.sv
`include "pim_consts.svh"

module input_filter (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   active_i,
  input  wire logic [`PIM_FILT_W-1:0] filter_time_i,
  output logic                        filtered_o
);

  pim_pkg::filter_state_type st_r;
  pim_pkg::filter_state_type st_nxt;

  // any drop restarts the wait, so only an unbroken active spell is accepted
  always_comb begin
    st_nxt     = st_r;
    st_nxt.act = active_i;
    if (!st_r.act) begin
      st_nxt.sub  = '0;
      st_nxt.cnt  = '0;
      st_nxt.filt = 1'b0;
    end else if (st_r.cnt >= filter_time_i) begin
      st_nxt.filt = 1'b1;
    end else if (st_r.sub == `PIM_SUB_LAST) begin
      st_nxt.sub = '0;
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end else begin
      st_nxt.sub = st_r.sub + 7'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign filtered_o = st_r.filt;

  accept_after_time_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(filtered_o) |-> $past(st_r.act) && ($past(st_r.cnt) >= $past(filter_time_i)))
    else $error("input accepted before debounce time elapsed");

  release_fast_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !active_i |=> ##1 !filtered_o)
    else $error("filtered input stayed active after input dropped");

endmodule // input_filter

// File: core/programmable_input_mapper.sv
// Notes on behaviour
// - every input has its own function code
// - disabled inputs never drive anything
// - motion enable input drives command bit 0
// - stop, production, fluidic drive bits 1-3
// - reference, clear fault, clear alert: bits 4-6
// - load drives bit 7, crossover bit 8
// - park and unpark drive bits 9, 10
// - unstick, torque test, clear required: 11-13
// - production and fluidic gates: bits 14, 15
// - lock panel items while lock input inactive
// - invert setting makes no-voltage the active level
// - present state of each input is readable
// - accept active only after full debounce time
// - test mode forces logic and aux outputs
// - forced outputs come from their value settings
`include "pim_consts.svh"

module programmable_input_mapper (
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 rst_n_i,
  input  wire logic [`PIM_NUM_LOGIC-1:0]            logic_input_i,
  input  wire logic [`PIM_NUM_DRY-1:0]              dry_contact_input_i,
  input  wire logic [`PIM_NUM_IN*`PIM_CFG_W-1:0]    input_func_cfg_i,
  input  wire logic [`PIM_NUM_IN-1:0]               input_invert_i,
  input  wire logic [`PIM_FILT_W-1:0]               input_filter_time_i,
  input  wire logic [`PIM_ITEMS_W-1:0]              panel_lock_cfg_i,
  input  wire logic                                 output_force_mode_i,
  input  wire logic [`PIM_NUM_LOGIC-1:0]            logic_out_normal_i,
  input  wire logic [`PIM_NUM_DRY-1:0]              aux_out_normal_i,
  input  wire logic [`PIM_NUM_LOGIC-1:0]            logic_out_force_i,
  input  wire logic [`PIM_NUM_DRY-1:0]              aux_out_force_i,
  output logic      [`PIM_CMD_W-1:0]                command_word_o,
  output logic                                      panel_lock_o,
  output logic      [`PIM_ITEMS_W-1:0]              panel_lock_items_o,
  output logic      [`PIM_NUM_IN-1:0]               input_value_o,
  output logic      [`PIM_NUM_LOGIC-1:0]            logic_out_o,
  output logic      [`PIM_NUM_DRY-1:0]              aux_out_o
);

  pim_pkg::mapper_state_type st_r;
  pim_pkg::mapper_state_type st_nxt;

  logic [`PIM_NUM_IN-1:0]                 raw;
  logic [`PIM_NUM_IN-1:0]                 act;
  logic [`PIM_NUM_IN-1:0]                 filt;
  logic [`PIM_NUM_IN-1:0]                 rise;
  logic [`PIM_NUM_IN-1:0]                 lock_sel;
  logic [`PIM_NUM_IN-1:0]                 no_func;
  logic [`PIM_NUM_IN-1:0][`PIM_CMD_W-1:0] sel;
  logic [`PIM_CMD_W-1:0]                  level_hit;
  logic [`PIM_CMD_W-1:0]                  rise_hit;
  logic                                   lock_want;

  // logic inputs sit in the low bits, dry contacts above them
  assign raw = {dry_contact_input_i, logic_input_i};

  // voltage applied is active unless the invert setting turns it round
  assign act = raw ^ input_invert_i;

  // rising edge of the debounced level, seen once per activation
  assign rise = filt & ~st_r.prev;

  generate
    for (genvar i = 0; i < `PIM_NUM_IN; i++) begin : g_in
      pim_pkg::input_func_type func;

      // each input decodes its own slice of the configuration
      assign func = pim_pkg::input_func_type'(
        input_func_cfg_i[i*`PIM_CFG_W +: `PIM_CFG_W]);

      // function codes 1..16 map onto command bits 0..15; other codes
      // (disabled, lock, unused) select no command bit at all
      always_comb begin
        sel[i] = '0;
        if ((func >= pim_pkg::FN_MOTION) &&
            (func <= pim_pkg::FN_GATE_FLUID)) begin
          sel[i] = 16'h0001 << (func - pim_pkg::FN_MOTION);
        end else begin
          sel[i] = '0;
        end
      end

      assign lock_sel[i] = (func == pim_pkg::FN_PANEL_LOCK);
      // reserved codes above the lock code behave as disabled
      assign no_func[i]  = (func == pim_pkg::FN_DISABLED) || (func > pim_pkg::FN_PANEL_LOCK);

      input_filter u_filter (
        .sys_clk_i     (sys_clk_i),
        .rst_n_i       (rst_n_i),
        .active_i      (act[i]),
        .filter_time_i (input_filter_time_i),
        .filtered_o    (filt[i])
      );

      // per input, so every line and every function code 1..17 is watched wherever it sits
      motion_level_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_MOTION) && filt[i] |=> command_word_o[0])
        else $error("motion enable input did not raise command bit 0");

      stop_pulse_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_STOP) && rise[i] |=> command_word_o[1])
        else $error("stop trigger did not pulse command bit 1");

      prod_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_PRODUCTION) && rise[i] |=> command_word_o[2])
        else $error("production trigger did not pulse command bit 2");

      fluid_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_FLUIDIC) && rise[i] |=> command_word_o[3])
        else $error("fluidic trigger did not pulse command bit 3");

      ref_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_REFERENCE) && rise[i] |=> command_word_o[4])
        else $error("reference trigger did not pulse command bit 4");

      fault_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_CLEAR_FAULT) && rise[i] |=> command_word_o[5])
        else $error("clear fault trigger did not pulse command bit 5");

      alert_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_CLEAR_ALERT) && rise[i] |=> command_word_o[6])
        else $error("clear alert trigger did not pulse command bit 6");

      load_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_LOAD) && rise[i] |=> command_word_o[7])
        else $error("load trigger did not pulse command bit 7");

      cross_level_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_CROSSOVER) && filt[i] |=> command_word_o[8])
        else $error("crossover input did not hold command bit 8");

      park_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_PARK) && rise[i] |=> command_word_o[9])
        else $error("park trigger did not pulse command bit 9");

      unpark_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_UNPARK) && rise[i] |=> command_word_o[10])
        else $error("unpark trigger did not pulse command bit 10");

      unstick_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_UNSTICK) && rise[i] |=> command_word_o[11])
        else $error("unstick trigger did not pulse command bit 11");

      torque_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_TORQUE) && rise[i] |=> command_word_o[12])
        else $error("torque test trigger did not pulse command bit 12");

      clear_req_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_CLEAR_REQ) && rise[i] |=>
          command_word_o[13] && !command_word_o[12])
        else $error("clear required trigger landed on the wrong bit");

      gate_prod_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_GATE_PROD) && filt[i] |=> command_word_o[14])
        else $error("production gate input did not hold command bit 14");

      gate_fluid_map_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_GATE_FLUID) && filt[i] |=> command_word_o[15])
        else $error("fluidic gate input did not hold command bit 15");

      lock_input_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (func == pim_pkg::FN_PANEL_LOCK) && !filt[i] |=>
          panel_lock_o && (panel_lock_items_o == $past(panel_lock_cfg_i)))
        else $error("inactive lock input did not lock the panel");
    end
  endgenerate

  // several inputs on one function combine as a wired or
  always_comb begin
    level_hit = '0;
    rise_hit  = '0;
    lock_want = 1'b0;
    for (int i = 0; i < `PIM_NUM_IN; i++) begin
      level_hit = level_hit | (sel[i] & {`PIM_CMD_W{filt[i]}});
      rise_hit  = rise_hit | (sel[i] & {`PIM_CMD_W{rise[i]}});
      lock_want = lock_want | (lock_sel[i] & ~filt[i]);
    end
  end

  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = filt;

    // level functions follow the input, triggers give a one-cycle pulse
    st_nxt.cmd[0]     = level_hit[0];
    st_nxt.cmd[3:1]   = rise_hit[3:1];
    st_nxt.cmd[6:4]   = rise_hit[6:4];
    st_nxt.cmd[7]     = rise_hit[7];
    st_nxt.cmd[8]     = level_hit[8];
    st_nxt.cmd[10:9]  = rise_hit[10:9];
    st_nxt.cmd[13:11] = rise_hit[13:11];
    st_nxt.cmd[15:14] = level_hit[15:14];

    // panel stays locked while any lock input is inactive
    st_nxt.lock  = lock_want;
    if (lock_want) begin
      st_nxt.items = panel_lock_cfg_i;
    end else begin
      st_nxt.items = '0;
    end

    // raw corrected level, not the debounced one, so wiring faults show
    st_nxt.vals = act;

    // forcing is not held off while an operation runs; that is left
    // to whoever enables test mode
    if (output_force_mode_i) begin
      st_nxt.lout = logic_out_force_i;
      st_nxt.aout = aux_out_force_i;
    end else begin
      st_nxt.lout = logic_out_normal_i;
      st_nxt.aout = aux_out_normal_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign command_word_o     = st_r.cmd;
  assign panel_lock_o       = st_r.lock;
  assign panel_lock_items_o = st_r.items;
  assign input_value_o      = st_r.vals;
  assign logic_out_o        = st_r.lout;
  assign aux_out_o          = st_r.aout;

  // checks

  disabled_silent_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (input_func_cfg_i == '0) |=>
      (command_word_o == '0) && !panel_lock_o)
    else $error("disabled inputs produced a command or lock");

  unused_silent_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (&no_func) |=> (command_word_o == '0) && !panel_lock_o)
    else $error("disabled or reserved codes produced a command or lock");

  lock_release_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ((lock_sel & ~filt) == '0) |=> !panel_lock_o && (panel_lock_items_o == '0))
    else $error("panel stayed locked with no inactive lock input");

  quiet_when_idle_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (filt == '0) |=> (command_word_o == '0))
    else $error("command raised with no debounced input");

  trigger_once_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (rise == '0) |=> ((command_word_o & ~`PIM_LEVEL_MASK) == '0))
    else $error("trigger pulsed without a rising edge");

  trigger_single_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    command_word_o[7] && (rise == '0) |=> !command_word_o[7])
    else $error("load trigger pulsed twice for one activation");

  lock_items_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    lock_want |=> panel_lock_o && (panel_lock_items_o == $past(panel_lock_cfg_i)))
    else $error("panel lock did not follow an inactive lock input");

  value_track_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 input_value_o == $past(raw ^ input_invert_i))
    else $error("input value readback does not track the corrected input");

  force_out_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    output_force_mode_i |=>
      (logic_out_o == $past(logic_out_force_i)) && (aux_out_o == $past(aux_out_force_i)))
    else $error("test mode did not force the outputs");

  normal_out_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !output_force_mode_i |=>
      (logic_out_o == $past(logic_out_normal_i)) && (aux_out_o == $past(aux_out_normal_i)))
    else $error("outputs forced while test mode was off");

endmodule // programmable_input_mapper

// File: bench/input_driver.sv
module input_driver (
  input  wire logic [5:0] active_i,
  input  wire logic [5:0] invert_i,
  output logic      [3:0] logic_line_o,
  output logic      [1:0] dry_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // field wiring: an inverted input is active when no voltage is applied
  assign {dry_line_o, logic_line_o} = active_i ^ invert_i;
endmodule // input_driver

// File: bench/tb_top.sv
`include "pim_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [5:0]  act       = 6'h00;
  logic [5:0]  inv       = 6'h00;
  logic [29:0] cfg       = 30'h0;
  logic [15:0] filt      = 16'h0000;
  logic [7:0]  items     = 8'h00;
  logic        force_en  = 1'b0;
  logic [11:0] outs      = 12'h000;
  logic [15:0] lmask     = `PIM_LEVEL_MASK;
  logic [24:0] seen      = 25'h0;
  logic [31:0] lfsr      = 32'h7bb7b5b4;
  logic [3:0]  lin;
  logic [1:0]  din;
  logic [15:0] cmd;
  logic        lock;
  logic [7:0]  litems;
  logic [5:0]  rval;
  logic [3:0]  lout;
  logic [1:0]  aout;
  logic [24:0] exp_q[$];
  int          due_q[$];
  int          cyc = 0;
  int          failures = 0;
  int          n_tests = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  input_driver input_driver_i (.active_i(act), .invert_i(inv), .logic_line_o(lin),
    .dry_line_o(din));

  programmable_input_mapper programmable_input_mapper_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .logic_input_i(lin),
    .dry_contact_input_i(din), .input_func_cfg_i(cfg), .input_invert_i(inv),
    .input_filter_time_i(filt), .panel_lock_cfg_i(items),
    .output_force_mode_i(force_en), .logic_out_normal_i(outs[11:8]),
    .aux_out_normal_i(outs[7:6]), .logic_out_force_i(outs[5:2]),
    .aux_out_force_i(outs[1:0]), .command_word_o(cmd), .panel_lock_o(lock),
    .panel_lock_items_o(litems), .input_value_o(rval), .logic_out_o(lout),
    .aux_out_o(aout));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic note(input logic [24:0] v, input int due);
    exp_q.push_back(v);
    due_q.push_back(due);
  endtask

  // inputs move 1 ns after the edge so the design never samples them mid-change
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // every change of command word or lock must match the oldest note; due 0 = any time
  always @(posedge sys_clk_i) begin : watch
    int d;
    cyc++;
    #2;
    if (rst_n_i && {cmd, lock, litems} !== seen) begin
      seen = {cmd, lock, litems};
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0, "output change with nothing pending");
      end else begin
        d = due_q.pop_front();
        chk(32'(seen), 32'(exp_q.pop_front()), "command or lock value");
        if (d != 0) chk(cyc, d, "response edge");
      end
    end
  end

  initial begin
    #50us;
    failures++;
    end_sim();
  end

  initial begin : main
    int          n;
    logic [31:0] r;
    logic        lvl;
    tick(16);
    chk(32'({cmd, lock, litems, rval, lout, aout}), 32'h0, "reset outputs");
    rst_n_i = 1'b1;
    tick(2);
    for (int f = 1; f <= 16; f++) begin
      n = f % 6;
      r = rnd();
      lvl = lmask[f-1];
      cfg[5*n +: 5] = 5'(f);
      inv[n] = r[0];
      tick(4);
      act[n] = 1'b1;
      note({16'h0001 << (f - 1), 9'h000}, cyc + 3);
      if (!lvl) note(25'h0, cyc + 4);
      tick(8);
      chk(32'(rval), 32'(6'h01 << n), "input readback");
      act[n] = 1'b0;
      if (lvl) note(25'h0, cyc + 3);
      tick(6);
      cfg[5*n +: 5] = 5'h00;
    end
    // disabled and unused codes must leave the command word and panel lock alone
    for (int k = 0; k < 15; k++) begin
      r = rnd();
      n = 32'(r[7:0]) % 6;
      cfg[5*n +: 5] = (k == 0) ? 5'h00 : 5'(17 + k);
      act[n] = 1'b1;
      tick(6);
      act[n] = 1'b0;
      tick(4);
      cfg = 30'h0;
    end
    filt = 16'h0001;
    cfg[4:0] = 5'h01;
    tick(2);
    act[0] = 1'b1;
    tick(100);
    act[0] = 1'b0;
    tick(3);
    act[0] = 1'b1;
    note({16'h0001, 9'h000}, cyc + 128);
    tick(140);
    act[0] = 1'b0;
    note(25'h0, cyc + 3);
    tick(6);
    filt = 16'h0000;
    r = rnd();
    items = r[7:0] | 8'h01;
    cfg = 30'h0;
    cfg[24:20] = 5'h11;
    note({16'h0, 1'b1, items}, 0);
    tick(8);
    act[4] = 1'b1;
    note(25'h0, cyc + 3);
    tick(6);
    act[4] = 1'b0;
    note({16'h0, 1'b1, items}, cyc + 3);
    tick(6);
    cfg = 30'h0;
    note(25'h0, 0);
    tick(6);
    // force only while no input is active, so nothing is running underneath
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      outs = r[11:0];
      force_en = r[12] ^ k[0];
      tick(2);
      chk(32'({lout, aout}), 32'(force_en ? outs[5:0] : outs[11:6]), "outputs");
    end
    tick(10);
    chk(exp_q.size(), 0, "notes left unmatched");
    end_sim();
  end
endmodule // tb_top
